// >>> rtl/pdim_map.vh
// register indices, field positions and reset values of the done-interrupt masking block
`ifndef PDIM_MAP_VH
`define PDIM_MAP_VH

// register indices; byte address on the bus is four times the index
`define PDIM_IDX_ENABLE      8'hd6
`define PDIM_IDX_STREAM_OR   8'hd8
`define PDIM_IDX_POLL_OR     8'hda
`define PDIM_IDX_ASYNC_OR    8'hdc
`define PDIM_IDX_STREAM_AND  8'hde
`define PDIM_IDX_POLL_AND    8'he0
`define PDIM_IDX_ASYNC_AND   8'he2
`define PDIM_IDX_STATUS      8'he4
`define PDIM_IDX_IRQ_MASK    8'he5
`define PDIM_IDX_LIVE        8'he6

// address fields
`define PDIM_ADDR_IDX_HI     9
`define PDIM_ADDR_IDX_LO     2
`define PDIM_ADDR_TOP        31
`define PDIM_ADDR_UP_LO      10
`define PDIM_ADDR_UP_ZERO    22'h000000

// bit positions shared by enable, status, mask and live registers
`define PDIM_BIT_STREAM      9
`define PDIM_BIT_ASYNC       8
`define PDIM_BIT_POLL        7

// internal group numbering
`define PDIM_GRP_STREAM      0
`define PDIM_GRP_POLL        1
`define PDIM_GRP_ASYNC       2

// reset values and fills
`define PDIM_MASK_RST        16'h0000
`define PDIM_GRP_RST         3'h0
`define PDIM_ZERO32          32'h00000000
`define PDIM_ZERO16          16'h0000

// ahb-lite encodings
`define PDIM_HTRANS_ACT_BIT  1
`define PDIM_HRESP_OKAY      1'b0

`endif

// >>> rtl/pdim_group_eval.v
// completion condition of one schedule type from its done map and its two masks
`timescale 1ns/100ps
`include "pdim_map.vh"

module pdim_group_eval (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // descriptor done map and masks
  input  wire [15:0] done_map,
  input  wire [15:0] or_mask,
  input  wire [15:0] and_mask,
  input  wire        enable,
  // results
  output wire        hit,
  output wire        event_pulse
);

  reg hit_d_r;

  function grp_hit;
    input [15:0] done;
    input [15:0] om;
    input [15:0] am;
    begin
      // a cleared mask bit keeps its descriptor out of either condition
      grp_hit = (|(done & om)) ||                                   // R2 R4 R6 R10 R16
                ((am != `PDIM_ZERO16) && ((done & am) == am));      // R8 R9 R12 R16
    end
  endfunction

  assign hit = grp_hit(done_map, or_mask, and_mask);

  // enable gates the event, so a disabled group raises nothing even if it stays met
  assign event_pulse = enable & hit & ~hit_d_r;                     // R13 R14 R15

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_d_r <= 1'b0;
    end else begin
      hit_d_r <= hit & enable;
    end
  end

endmodule // pdim_group_eval

// >>> rtl/pdim_top.v
// ahb-lite register file and interrupt logic for descriptor done masking
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "pdim_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: a 16-bit stream or-mask register maps bit n to stream descriptor n, n from 15 down to 0.
// R2: a one puts that stream descriptor in the or group, a zero keeps it out of any or condition.
// R3: a 16-bit poll or-mask register maps bit n to poll descriptor n, n from 15 down to 0.
// R4: a one puts that poll descriptor in the or condition, a zero adds no or condition.
// R5: a 16-bit async or-mask register maps bit n to async descriptor n, n from 15 down to 0.
// R6: a one adds that async descriptor to the or condition, a zero defines none for it.
// R7: a 16-bit stream and-mask register maps bit n to stream descriptor n, n from 15 down to 0.
// R8: a one puts that stream descriptor in the and group, a zero leaves it out.
// R9: a 16-bit poll and-mask register maps bit n to poll descriptor n, a one joins the and group.
// R10: every mask bit masks the done bit of its own descriptor, sixteen per schedule type.
// R11: all mask registers are read and write and clear to zero on reset, so no group is active.
// R12: a 16-bit async and-mask register maps bit n to async descriptor n and defines an and group.
// R13: enable bit 9 lets a met stream condition raise the interrupt, zero suppresses it.
// R14: enable bit 8 lets a met async condition raise the interrupt, zero suppresses it.
// R15: enable bit 7 lets a met poll condition raise the interrupt, zero suppresses it.
// R16: a type's event fires when any or-masked descriptor is done or all of a nonzero and mask are done.
module pdim_top (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // descriptor done maps from the schedule engine
  input  wire [15:0] stream_done_map,
  input  wire [15:0] poll_done_map,
  input  wire [15:0] async_done_map,
  // interrupt
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  reg  [15:0] stream_or_r;
  reg  [15:0] poll_or_r;
  reg  [15:0] async_or_r;
  reg  [15:0] stream_and_r;
  reg  [15:0] poll_and_r;
  reg  [15:0] async_and_r;
  reg  [2:0]  enable_r;
  reg  [2:0]  status_r;
  reg  [2:0]  irq_mask_r;

  reg  [15:0] stream_or_nxt;
  reg  [15:0] poll_or_nxt;
  reg  [15:0] async_or_nxt;
  reg  [15:0] stream_and_nxt;
  reg  [15:0] poll_and_nxt;
  reg  [15:0] async_and_nxt;
  reg  [2:0]  enable_nxt;
  reg  [2:0]  status_nxt;
  reg  [2:0]  irq_mask_nxt;

  reg         wr_pend_r;
  reg  [7:0]  wr_idx_r;
  reg         wr_ok_r;

  wire        acc;
  wire        addr_ok;
  wire [7:0]  acc_idx;
  wire [2:0]  hit;
  wire [2:0]  evt;
  reg  [31:0] rd_mux;

  wire        we_stream_or;
  wire        we_poll_or;
  wire        we_async_or;
  wire        we_stream_and;
  wire        we_poll_and;
  wire        we_async_and;
  wire        we_enable;
  wire        we_status;
  wire        we_irq_mask;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // one write select used by every register below
  function wr_sel;
    input       pend;
    input       ok;
    input [7:0] cur;
    input [7:0] idx;
    begin
      wr_sel = pend & ok & (cur == idx);
    end
  endfunction

  // places the three group bits at their bus positions
  function [31:0] grp_word;
    input [2:0] g;
    reg   [31:0] w;
    begin
      w = `PDIM_ZERO32;
      w[`PDIM_BIT_STREAM] = g[`PDIM_GRP_STREAM];
      w[`PDIM_BIT_POLL]   = g[`PDIM_GRP_POLL];
      w[`PDIM_BIT_ASYNC]  = g[`PDIM_GRP_ASYNC];
      grp_word = w;
    end
  endfunction

  // picks the three group bits out of a bus word
  function [2:0] grp_bits;
    input [31:0] w;
    begin
      grp_bits = {w[`PDIM_BIT_ASYNC], w[`PDIM_BIT_POLL], w[`PDIM_BIT_STREAM]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase

  // zero wait states: the slave never stretches a transfer
  assign hreadyout = 1'b1;
  assign hresp     = `PDIM_HRESP_OKAY;

  assign acc     = hsel & hready & htrans[`PDIM_HTRANS_ACT_BIT];
  assign acc_idx = haddr[`PDIM_ADDR_IDX_HI:`PDIM_ADDR_IDX_LO];
  // upper address bits must be zero, otherwise the access is unmapped
  assign addr_ok = (haddr[`PDIM_ADDR_TOP:`PDIM_ADDR_UP_LO] == `PDIM_ADDR_UP_ZERO);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
      wr_ok_r   <= 1'b0;
    end else begin
      wr_pend_r <= acc & hwrite;
      wr_idx_r  <= acc_idx;
      wr_ok_r   <= addr_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write strobes

  // decoded from the data-phase copy, since the address bus has already moved on by then
  assign we_stream_or  = wr_sel(wr_pend_r, wr_ok_r, wr_idx_r, `PDIM_IDX_STREAM_OR);
  assign we_poll_or    = wr_sel(wr_pend_r, wr_ok_r, wr_idx_r, `PDIM_IDX_POLL_OR);
  assign we_async_or   = wr_sel(wr_pend_r, wr_ok_r, wr_idx_r, `PDIM_IDX_ASYNC_OR);
  assign we_stream_and = wr_sel(wr_pend_r, wr_ok_r, wr_idx_r, `PDIM_IDX_STREAM_AND);
  assign we_poll_and   = wr_sel(wr_pend_r, wr_ok_r, wr_idx_r, `PDIM_IDX_POLL_AND);
  assign we_async_and  = wr_sel(wr_pend_r, wr_ok_r, wr_idx_r, `PDIM_IDX_ASYNC_AND);
  assign we_enable     = wr_sel(wr_pend_r, wr_ok_r, wr_idx_r, `PDIM_IDX_ENABLE);
  assign we_status     = wr_sel(wr_pend_r, wr_ok_r, wr_idx_r, `PDIM_IDX_STATUS);
  assign we_irq_mask   = wr_sel(wr_pend_r, wr_ok_r, wr_idx_r, `PDIM_IDX_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////////
  // completion evaluation per schedule type

  pdim_group_eval u_stream (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .done_map    (stream_done_map),
    .or_mask     (stream_or_r),
    .and_mask    (stream_and_r),
    .enable      (enable_r[`PDIM_GRP_STREAM]),
    .hit         (hit[`PDIM_GRP_STREAM]),
    .event_pulse (evt[`PDIM_GRP_STREAM])
  );

  pdim_group_eval u_poll (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .done_map    (poll_done_map),
    .or_mask     (poll_or_r),
    .and_mask    (poll_and_r),
    .enable      (enable_r[`PDIM_GRP_POLL]),
    .hit         (hit[`PDIM_GRP_POLL]),
    .event_pulse (evt[`PDIM_GRP_POLL])
  );

  pdim_group_eval u_async (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .done_map    (async_done_map),
    .or_mask     (async_or_r),
    .and_mask    (async_and_r),
    .enable      (enable_r[`PDIM_GRP_ASYNC]),
    .hit         (hit[`PDIM_GRP_ASYNC]),
    .event_pulse (evt[`PDIM_GRP_ASYNC])
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register next values

  always @* begin
    stream_or_nxt  = stream_or_r;
    poll_or_nxt    = poll_or_r;
    async_or_nxt   = async_or_r;
    stream_and_nxt = stream_and_r;
    poll_and_nxt   = poll_and_r;
    async_and_nxt  = async_and_r;
    enable_nxt     = enable_r;
    irq_mask_nxt   = irq_mask_r;
    if (we_stream_or) begin
      stream_or_nxt = hwdata[15:0];                                 // R1 R11
    end
    if (we_poll_or) begin
      poll_or_nxt = hwdata[15:0];                                   // R3 R11
    end
    if (we_async_or) begin
      async_or_nxt = hwdata[15:0];                                  // R5 R11
    end
    if (we_stream_and) begin
      stream_and_nxt = hwdata[15:0];                                // R7 R11
    end
    if (we_poll_and) begin
      poll_and_nxt = hwdata[15:0];                                  // R9 R11
    end
    if (we_async_and) begin
      async_and_nxt = hwdata[15:0];                                 // R12 R11
    end
    if (we_enable) begin
      enable_nxt = grp_bits(hwdata);                                // R13 R14 R15
    end
    if (we_irq_mask) begin
      irq_mask_nxt = grp_bits(hwdata);
    end
  end

  // write-one-to-clear, but a new event in the same cycle keeps its bit set
  always @* begin
    status_nxt = status_r;
    if (we_status) begin
      status_nxt = status_r & ~grp_bits(hwdata);
    end
    status_nxt = status_nxt | evt;                                  // R13 R14 R15 R16
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stream_or_r  <= `PDIM_MASK_RST;                               // R11
      poll_or_r    <= `PDIM_MASK_RST;
      async_or_r   <= `PDIM_MASK_RST;
      stream_and_r <= `PDIM_MASK_RST;
      poll_and_r   <= `PDIM_MASK_RST;
      async_and_r  <= `PDIM_MASK_RST;
      enable_r     <= `PDIM_GRP_RST;
      status_r     <= `PDIM_GRP_RST;
      irq_mask_r   <= `PDIM_GRP_RST;
    end else begin
      stream_or_r  <= stream_or_nxt;
      poll_or_r    <= poll_or_nxt;
      async_or_r   <= async_or_nxt;
      stream_and_r <= stream_and_nxt;
      poll_and_r   <= poll_and_nxt;
      async_and_r  <= async_and_nxt;
      enable_r     <= enable_nxt;
      status_r     <= status_nxt;
      irq_mask_r   <= irq_mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  // the mux reads next values, so a read right behind a write sees the new data
  always @* begin
    rd_mux = `PDIM_ZERO32;
    if (addr_ok) begin
      case (acc_idx)
        `PDIM_IDX_STREAM_OR:  rd_mux[15:0] = stream_or_nxt;        // R11
        `PDIM_IDX_POLL_OR:    rd_mux[15:0] = poll_or_nxt;
        `PDIM_IDX_ASYNC_OR:   rd_mux[15:0] = async_or_nxt;
        `PDIM_IDX_STREAM_AND: rd_mux[15:0] = stream_and_nxt;
        `PDIM_IDX_POLL_AND:   rd_mux[15:0] = poll_and_nxt;
        `PDIM_IDX_ASYNC_AND:  rd_mux[15:0] = async_and_nxt;
        `PDIM_IDX_ENABLE:     rd_mux = grp_word(enable_nxt);
        `PDIM_IDX_STATUS:     rd_mux = grp_word(status_nxt);
        `PDIM_IDX_IRQ_MASK:   rd_mux = grp_word(irq_mask_nxt);
        `PDIM_IDX_LIVE:       rd_mux = grp_word(hit);
        default:              rd_mux = `PDIM_ZERO32;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `PDIM_ZERO32;
    end else if (acc & ~hwrite) begin
      hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt output

  // level output: stays high until software clears or masks every set status bit
  assign irq = |(status_r & irq_mask_r);                            // R13 R14 R15

endmodule // pdim_top

// >>> bench/pdim_chk_sva.sv
// assertion checker on the pins of the done-interrupt masking block
`timescale 1ns/100ps
module pdim_chk (
  // clock and reset
  input logic        hclk,
  input logic        hresetn,
  // bus
  input logic        hsel,
  input logic        hready,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] haddr,
  input logic        hreadyout,
  input logic        hresp,
  input logic [31:0] hrdata,
  // done maps and interrupt
  input logic [15:0] stream_done_map,
  input logic [15:0] poll_done_map,
  input logic [15:0] async_done_map,
  input logic        irq
);
  ////////////////////////////////////////////////////////////
  logic        rd_a;
  logic        wr_a;
  logic        wr_q_r;
  logic        wr_d_r;
  logic [2:0]  act_r;
  logic [47:0] map_r;
  assign rd_a = hsel & hready & htrans[1] & ~hwrite;
  assign wr_a = hsel & hready & htrans[1] & hwrite;
  // an irq edge needs a cause: a write or a done map change shortly before
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q_r <= 1'b0;
      wr_d_r <= 1'b0;
      act_r  <= 3'h0;
      map_r  <= 48'h0;
    end else begin
      wr_q_r <= wr_a;
      wr_d_r <= wr_q_r;
      map_r  <= {stream_done_map, poll_done_map, async_done_map};
      act_r  <= {act_r[1:0], wr_q_r | ({stream_done_map, poll_done_map, async_done_map} != map_r)};
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
  chk_rdata_hold: assert property (!rd_a |=> $stable(hrdata)) else $error("hrdata moved");
  chk_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper read bits set");
  chk_unmapped_rd: assert property (rd_a && haddr[31:10] != 22'h0 |=> hrdata == 32'h0) else $error("alias read");
  chk_irq_cause: assert property ($rose(irq) |-> act_r != 3'h0) else $error("irq without cause");
  chk_irq_clear: assert property ($fell(irq) |-> wr_d_r) else $error("irq fell without write");
  chk_reset_quiet: assert property ($rose(hresetn) |-> !irq && hrdata == 32'h0) else $error("not clear");
endmodule // pdim_chk

bind pdim_top pdim_chk pdim_chk_i (.hclk, .hresetn, .hsel, .hready, .htrans, .hwrite, .haddr, .hreadyout,
  .hresp, .hrdata, .stream_done_map, .poll_done_map, .async_done_map, .irq);

// >>> bench/tb_top.sv
// register and interrupt testbench of the done-interrupt masking block
`timescale 1ns/100ps
`include "pdim_map.vh"
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rv, gb;
  logic [15:0] stream_done_map, poll_done_map, async_done_map;
  logic [7:0]  oi [3] = '{`PDIM_IDX_STREAM_OR, `PDIM_IDX_POLL_OR, `PDIM_IDX_ASYNC_OR};
  logic [7:0]  ai [3] = '{`PDIM_IDX_STREAM_AND, `PDIM_IDX_POLL_AND, `PDIM_IDX_ASYNC_AND};
  logic [7:0]  mi [6] = '{`PDIM_IDX_STREAM_OR, `PDIM_IDX_POLL_OR, `PDIM_IDX_ASYNC_OR,
                          `PDIM_IDX_STREAM_AND, `PDIM_IDX_POLL_AND, `PDIM_IDX_ASYNC_AND};
  integer      bt [3] = '{`PDIM_BIT_STREAM, `PDIM_BIT_POLL, `PDIM_BIT_ASYNC};
  integer      n_errors, n_compared, g, i;
  pdim_top pdim_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .stream_done_map, .poll_done_map, .async_done_map, .irq);
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////
  task end_of_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task chk_irq(input logic e);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // waits for ready at a rising edge; the bound stands in for a hung slave
  task rdy;
    integer k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      $display("Error %0t: bus hang", $time);
      end_of_test;
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    rdy;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    rv = hrdata;
  endtask
  function logic [31:0] ra(input logic [7:0] x);
    ra = {22'h0, x, 2'b00};
  endfunction
  task wr(input logic [7:0] x, input logic [31:0] d);
    bus(1'b1, ra(x), d);
  endtask
  task rd(input logic [7:0] x, input logic [31:0] e);
    bus(1'b0, ra(x), 32'h0);
    chk(rv, e);
  endtask
  task dn(input logic [15:0] v);
    case (g)
      0: stream_done_map <= v;
      1: poll_done_map <= v;
      default: async_done_map <= v;
    endcase
  endtask
  task tk(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    n_compared = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {stream_done_map, poll_done_map, async_done_map} = '0;
    g = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 6; i++) rd(mi[i], 32'h0);
    for (i = 0; i < 6; i++) begin
      wr(mi[i], 32'hffff_a5c3 ^ (i << 4));
      rd(mi[i], 32'h0000_a5c3 ^ (i << 4));
    end
    // upper address bits set alias index 0xd8 and must be ignored
    bus(1'b1, 32'h0000_0760, 32'h0000_0f0f);
    bus(1'b0, 32'h0000_0760, 32'h0);
    chk(rv, 32'h0);
    rd(mi[0], 32'h0000_a5c3);
    rd(8'h10, 32'h0);
    // second reset in mid-run: masks written above must clear again
    hresetn <= 1'b0;
    tk(2);
    hresetn <= 1'b1;
    tk(1);
    for (i = 0; i < 6; i++) rd(mi[i], 32'h0);
    chk_irq(1'b0);
    for (i = 0; i < 6; i++) wr(mi[i], 32'h0);
    // only the three group bits exist in the enable and interrupt mask words
    wr(`PDIM_IDX_ENABLE, 32'hffff_ffff);
    rd(`PDIM_IDX_ENABLE, 32'h0000_0380);
    wr(`PDIM_IDX_IRQ_MASK, 32'hffff_ffff);
    rd(`PDIM_IDX_IRQ_MASK, 32'h0000_0380);
    for (g = 0; g < 3; g++) begin
      gb = 32'h1 << bt[g];
      wr(`PDIM_IDX_ENABLE, gb);
      wr(`PDIM_IDX_IRQ_MASK, gb);
      wr(oi[g], 32'h0008);
      dn(16'h0004);
      tk(2);
      chk_irq(1'b0);
      rd(`PDIM_IDX_LIVE, 32'h0);
      dn(16'h000c);
      tk(2);
      chk_irq(1'b1);
      rd(`PDIM_IDX_STATUS, gb);
      wr(`PDIM_IDX_STATUS, gb);
      tk(2);
      chk_irq(1'b0);
      dn(16'h0);
      wr(oi[g], 32'h0);
      wr(ai[g], 32'h8001);
      dn(16'h8000);
      tk(2);
      chk_irq(1'b0);
      dn(16'h8001);
      tk(2);
      chk_irq(1'b1);
      wr(`PDIM_IDX_IRQ_MASK, 32'h0);
      tk(1);
      chk_irq(1'b0);
      rd(`PDIM_IDX_STATUS, gb);
      wr(`PDIM_IDX_IRQ_MASK, gb);
      tk(1);
      chk_irq(1'b1);
      wr(`PDIM_IDX_STATUS, gb);
      wr(`PDIM_IDX_ENABLE, 32'h0);
      dn(16'h0);
      tk(2);
      dn(16'h8001);
      tk(2);
      rd(`PDIM_IDX_STATUS, 32'h0);
      rd(`PDIM_IDX_LIVE, gb);
      chk_irq(1'b0);
      wr(ai[g], 32'h0);
      dn(16'h0);
    end
    end_of_test;
  end
endmodule // tb_top
